//--- rtl/dcf_fifo_top.sv
// Programmable-flag FIFO: array, pointers, status flags and output register
`timescale 1ns/1ps
//////////////////////////////////////////////////////////////////////////////////////////
module dcf_fifo_top
    import dcf_pkg::*;
#(
    parameter int DEPTH       = DCF_DEPTH_DEF,
    parameter int STAGE_DEPTH = DCF_STAGE_DEPTH
) (
    input  wire logic                  i_clk,
    input  wire logic                  i_resetn,
    input  wire logic [DCF_DATA_W-1:0] i_data_in,
    input  wire logic                  i_write_enable_n,
    input  wire logic                  i_read_enable_n,
    input  wire logic                  i_offset_load_n,
    input  wire logic                  i_output_drive_n,
    input  wire logic                  i_first_in_chain_n,
    input  wire logic                  i_write_chain_in_n,
    input  wire logic                  i_read_chain_in_n,
    output logic      [DCF_DATA_W-1:0] o_data_out,
    output logic                       o_data_out_oe,
    output logic                       o_full_flag_n,
    output logic                       o_empty_flag_n,
    output logic                       o_almost_full_n,
    output logic                       o_almost_empty_n,
    output logic                       o_write_chain_out_n,
    output logic                       o_read_chain_out_n
);
    localparam int AW = $clog2(DEPTH);
    localparam int CW = AW + 2;
    localparam logic [CW-1:0] FULL_COUNT = CW'(DEPTH);
    localparam logic [CW-1:0] HALF_COUNT = CW'(DEPTH / 2);
    // Threshold compares run wide enough for any 12-bit offset, so large offsets are never cut
    localparam int            TW         = ((CW > DCF_OFFS_W) ? CW : DCF_OFFS_W) + 1;

    //////////////////////////////////////////////////////////////////////////////////////
    // Storage and counts
    logic [DCF_DATA_W-1:0] mem [DEPTH];
    logic [AW-1:0]         wr_ptr;
    logic [AW-1:0]         rd_ptr;
    logic [CW-1:0]         total_count;
    logic [CW-1:0]         ram_count;
    logic [CW-1:0]         next_total_count;
    logic [CW-1:0]         next_ram_count;
    logic                  half_full_n;
    logic [11:0]           empty_threshold;
    logic [11:0]           full_threshold;
    logic [11:0]           offset_fetch_data;

    dcf_stream_if #(.W(DCF_DATA_W)) stage_in ();
    dcf_stream_if #(.W(DCF_DATA_W)) stage_out ();

    //////////////////////////////////////////////////////////////////////////////////////
    // Request decode
    wire normal_mode  = i_offset_load_n;
    wire write_req    = normal_mode & ~i_write_enable_n;
    wire read_req     = normal_mode & ~i_read_enable_n;
    // Full flag gates the write; the staging FIFO's ready stalls it as well
    wire write_accept = write_req & o_full_flag_n & stage_in.ready;
    // Only words already in the array may be read; reads while empty are dropped
    wire read_accept  = read_req & o_empty_flag_n;
    wire drain        = stage_out.valid & stage_out.ready;
    wire offset_load  = ~i_offset_load_n & ~i_write_enable_n;
    wire offset_fetch = ~i_offset_load_n & ~i_read_enable_n;
    wire chain_single = ~i_write_chain_in_n & ~i_read_chain_in_n;

    assign stage_in.valid  = write_accept;
    assign stage_in.data   = i_data_in;
    // The array always has room for what the staging FIFO holds, since full counts both
    assign stage_out.ready = 1'b1;

    assign next_total_count = total_count + CW'(write_accept) - CW'(read_accept);
    assign next_ram_count   = ram_count + CW'(drain) - CW'(read_accept);

    //////////////////////////////////////////////////////////////////////////////////////
    // Submodules
    dcf_stage_fifo #(
        .W     (DCF_DATA_W),
        .DEPTH (STAGE_DEPTH)
    ) u_stage (
        .i_clk    (i_clk),
        .i_resetn (i_resetn),
        .s_in     (stage_in),
        .s_out    (stage_out)
    );

    dcf_offset_regs #(
        .DEPTH (DEPTH)
    ) u_offsets (
        .i_clk             (i_clk),
        .i_resetn          (i_resetn),
        .i_load            (offset_load),
        .i_load_data       (i_data_in[DCF_OFFS_W-1:0]),
        .i_fetch           (offset_fetch),
        .o_empty_threshold (empty_threshold),
        .o_full_threshold  (full_threshold),
        .o_fetch_data      (offset_fetch_data)
    );

    //////////////////////////////////////////////////////////////////////////////////////
    // Pointers and counts
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            wr_ptr      <= '0;
            rd_ptr      <= '0;
            total_count <= '0;
            ram_count   <= '0;
        end else begin
            if (drain) begin
                wr_ptr <= wr_ptr + AW'(1);
            end
            if (read_accept) begin
                rd_ptr <= rd_ptr + AW'(1);
            end
            total_count <= next_total_count;
            ram_count   <= next_ram_count;
        end
    end

    always_ff @(posedge i_clk) begin
        if (drain) begin
            mem[wr_ptr] <= stage_out.data;
        end
    end

    //////////////////////////////////////////////////////////////////////////////////////
    // Output register
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_data_out <= DCF_DOUT_RESET;
        end else if (read_accept) begin
            o_data_out <= mem[rd_ptr];
        end else if (offset_fetch) begin
            o_data_out <= {DCF_OFFS_PAD, offset_fetch_data};
        end
    end
    // Otherwise the register holds, so data out stays still

    assign o_data_out_oe = ~i_output_drive_n;

    //////////////////////////////////////////////////////////////////////////////////////
    // Status flags, registered from the counts after this edge
    // Full and almost-full use the total including staged words; empty and
    // almost-empty use only words readable from the array, so they lag a write by one edge
    wire next_full_n     = (next_total_count != FULL_COUNT);
    wire next_empty_n    = (next_ram_count != '0);
    wire next_afull_n    = ((TW'(next_total_count) + TW'(full_threshold)) < TW'(DEPTH));
    wire next_aempty_n   = (TW'(next_ram_count) > TW'(empty_threshold));
    wire next_half_n     = (next_total_count <= HALF_COUNT);

    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_full_flag_n    <= 1'b1;
            o_empty_flag_n   <= 1'b0;
            o_almost_full_n  <= 1'b1;
            o_almost_empty_n <= 1'b0;
            half_full_n      <= 1'b1;
        end else begin
            o_full_flag_n    <= next_full_n;
            o_empty_flag_n   <= next_empty_n;
            o_almost_full_n  <= next_afull_n;
            o_almost_empty_n <= next_aempty_n;
            half_full_n      <= next_half_n;
        end
    end

    //////////////////////////////////////////////////////////////////////////////////////
    // Chain outputs; daisy-chain expansion is not supported, so outside single use
    // the chain outputs rest high
    assign o_write_chain_out_n = chain_single ? half_full_n : 1'b1;
    assign o_read_chain_out_n  = 1'b1;

endmodule : dcf_fifo_top

//--- rtl/dcf_pkg.sv
// Shared constants for the programmable-flag FIFO
package dcf_pkg;
    localparam int          DCF_DATA_W      = 18;
    localparam int          DCF_OFFS_W      = 12;
    localparam int          DCF_DEPTH_DEF   = 256;
    localparam int          DCF_STAGE_DEPTH = 4;
    localparam int          DCF_DEPTH_SMALL = 256;
    localparam int          DCF_DEPTH_MID   = 512;
    localparam logic [11:0] DCF_THR_SMALL   = 12'h01F;
    localparam logic [11:0] DCF_THR_MID     = 12'h03F;
    localparam logic [11:0] DCF_THR_LARGE   = 12'h07F;
    localparam logic [17:0] DCF_DOUT_RESET  = 18'h00000;
    localparam logic [5:0]  DCF_OFFS_PAD    = 6'h00;

    // Offset register selector, one-hot
    typedef enum logic [1:0] {
        DCF_SEL_EMPTY = 2'b01,
        DCF_SEL_FULL  = 2'b10
    } dcf_sel_e;

    function automatic logic [11:0] dcf_default_thr(input int depth);
        if (depth == DCF_DEPTH_SMALL) begin
            return DCF_THR_SMALL;
        end else if (depth == DCF_DEPTH_MID) begin
            return DCF_THR_MID;
        end
        return DCF_THR_LARGE;
    endfunction : dcf_default_thr
endpackage : dcf_pkg

//--- rtl/dcf_stream_if.sv
// Valid/ready word stream between the FIFO's own modules
`timescale 1ns/1ps
interface dcf_stream_if #(parameter int W = 18);
    logic         valid;
    logic         ready;
    logic [W-1:0] data;

    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface : dcf_stream_if

//--- rtl/dcf_stage_fifo.sv
// Small staging FIFO on the write data path
`timescale 1ns/1ps
module dcf_stage_fifo #(
    parameter int W     = 18,
    parameter int DEPTH = 4
) (
    input  wire logic i_clk,
    input  wire logic i_resetn,
    dcf_stream_if.snk s_in,
    dcf_stream_if.src s_out
);
    localparam int PW = $clog2(DEPTH);

    logic [W-1:0] mem [DEPTH];
    logic [PW-1:0] wr_ptr;
    logic [PW-1:0] rd_ptr;
    logic [PW:0]   used;
    wire           push = s_in.valid & s_in.ready;
    wire           pop  = s_out.valid & s_out.ready;

    assign s_in.ready  = (used != (PW+1)'(DEPTH)) ? 1'b1 : 1'b0;
    assign s_out.valid = (used != '0);
    assign s_out.data  = mem[rd_ptr];

    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            used   <= '0;
        end else begin
            if (push) begin
                wr_ptr <= (wr_ptr == PW'(DEPTH - 1)) ? '0 : wr_ptr + PW'(1);
            end
            if (pop) begin
                rd_ptr <= (rd_ptr == PW'(DEPTH - 1)) ? '0 : rd_ptr + PW'(1);
            end
            used <= used + (PW+1)'(push) - (PW+1)'(pop);
        end
    end

    // Storage needs no reset; only the pointers and the used count carry control state
    always_ff @(posedge i_clk) begin
        if (push) begin
            mem[wr_ptr] <= s_in.data;
        end
    end
endmodule : dcf_stage_fifo

//--- rtl/dcf_offset_regs.sv
// Empty and full threshold registers with load and readback sequencing
`timescale 1ns/1ps
module dcf_offset_regs
    import dcf_pkg::*;
#(
    parameter int DEPTH = DCF_DEPTH_DEF
) (
    input  wire logic        i_clk,
    input  wire logic        i_resetn,
    input  wire logic        i_load,
    input  wire logic [11:0] i_load_data,
    input  wire logic        i_fetch,
    output logic      [11:0] o_empty_threshold,
    output logic      [11:0] o_full_threshold,
    output logic      [11:0] o_fetch_data
);
    localparam logic [11:0] THR_DEFAULT = dcf_default_thr(DEPTH);

    dcf_sel_e wr_sel;
    dcf_sel_e rd_sel;

    assign o_fetch_data = (rd_sel == DCF_SEL_EMPTY) ? o_empty_threshold : o_full_threshold;

    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_empty_threshold <= THR_DEFAULT;
            o_full_threshold  <= THR_DEFAULT;
            wr_sel            <= DCF_SEL_EMPTY;
        end else if (i_load) begin
            unique case (wr_sel)
                DCF_SEL_EMPTY: begin
                    o_empty_threshold <= i_load_data;
                    wr_sel            <= DCF_SEL_FULL;
                end
                DCF_SEL_FULL: begin
                    o_full_threshold <= i_load_data;
                    wr_sel           <= DCF_SEL_EMPTY;
                end
            endcase
        end
    end

    // Readback walks its own selector so loads and fetches never disturb each other
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            rd_sel <= DCF_SEL_EMPTY;
        end else if (i_fetch) begin
            rd_sel <= (rd_sel == DCF_SEL_EMPTY) ? DCF_SEL_FULL : DCF_SEL_EMPTY;
        end
    end
endmodule : dcf_offset_regs

//--- tb/dcf_fifo_top_assertions.sv
// Port-level assertions for the programmable-flag FIFO
`timescale 1ns/1ps
module dcf_fifo_checker
    import dcf_pkg::*;
#(
    parameter int DEPTH       = DCF_DEPTH_DEF,
    parameter int STAGE_DEPTH = DCF_STAGE_DEPTH
) (
    input wire logic                  i_clk,
    input wire logic                  i_resetn,
    input wire logic                  i_write_enable_n,
    input wire logic                  i_read_enable_n,
    input wire logic                  i_offset_load_n,
    input wire logic                  i_output_drive_n,
    input wire logic [DCF_DATA_W-1:0] o_data_out,
    input wire logic                  o_data_out_oe,
    input wire logic                  o_full_flag_n,
    input wire logic                  o_empty_flag_n,
    input wire logic                  o_almost_full_n,
    input wire logic                  o_almost_empty_n,
    input wire logic                  o_write_chain_out_n
);
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_resetn);
    ////////////////////////////////////////////////////////////
    chk_bus_drive: assert property (o_data_out_oe == !i_output_drive_n)
        else $error("output enable does not follow drive input");
    chk_out_hold: assert property (i_read_enable_n |=> $stable(o_data_out))
        else $error("data out changed without a read");
    chk_empty_ignore: assert property (!i_read_enable_n && i_offset_load_n && !o_empty_flag_n |=> $stable(o_data_out))
        else $error("read taken while empty");
    chk_full_hold: assert property (!o_full_flag_n && i_read_enable_n |=> !o_full_flag_n)
        else $error("full flag released without a read");
    chk_full_release: assert property (!o_full_flag_n && !i_read_enable_n && i_offset_load_n && i_write_enable_n
        |-> ##[1:2] o_full_flag_n)
        else $error("full flag not released after read");
    chk_empty_stays: assert property (i_write_enable_n [*4] ##0 !o_empty_flag_n |=> !o_empty_flag_n)
        else $error("empty flag released without a write");
    chk_empty_release: assert property (!o_empty_flag_n && !i_write_enable_n && i_offset_load_n && o_full_flag_n
        |-> ##[1:3] o_empty_flag_n)
        else $error("empty flag not released after write");
    chk_flag_order: assert property (!o_full_flag_n |-> !o_almost_full_n && !o_write_chain_out_n && o_empty_flag_n)
        else $error("full without almost full and half full");
    chk_empty_almost: assert property (!o_empty_flag_n |-> !o_almost_empty_n)
        else $error("empty without almost empty");
    chk_reset_levels: assert property ($rose(i_resetn) |-> o_full_flag_n && !o_empty_flag_n && o_almost_full_n
        && !o_almost_empty_n && o_write_chain_out_n && o_data_out == 18'h00000)
        else $error("flags or data wrong after reset");
endmodule : dcf_fifo_checker

bind dcf_fifo_top dcf_fifo_checker #(.DEPTH(DEPTH), .STAGE_DEPTH(STAGE_DEPTH)) u_chk (
    .i_clk(i_clk), .i_resetn(i_resetn), .i_write_enable_n(i_write_enable_n), .i_read_enable_n(i_read_enable_n),
    .i_offset_load_n(i_offset_load_n), .i_output_drive_n(i_output_drive_n), .o_data_out(o_data_out),
    .o_data_out_oe(o_data_out_oe), .o_full_flag_n(o_full_flag_n), .o_empty_flag_n(o_empty_flag_n),
    .o_almost_full_n(o_almost_full_n), .o_almost_empty_n(o_almost_empty_n),
    .o_write_chain_out_n(o_write_chain_out_n));

//--- tb/dcf_far_side.sv
// Writer and reader logic facing the FIFO pins
`timescale 1ns/1ps
module dcf_far_side (
    input  wire logic        i_clk,
    input  wire logic        i_push,
    input  wire logic        i_pop,
    input  wire logic        i_load_n,
    input  wire logic [17:0] i_word,
    output logic             o_write_enable_n,
    output logic             o_read_enable_n,
    output logic      [17:0] o_data_in,
    output logic             o_straps_n
);
    logic [17:0] idle = 18'h2AAAA;
    // Idle data lines toggle so a stale word is never taken for a fresh one
    always @(negedge i_clk) idle <= ~idle;
    assign o_write_enable_n = !i_push;
    assign o_read_enable_n  = !(i_pop && !(i_push && !i_load_n));
    assign o_data_in        = !i_push ? idle : (i_load_n ? i_word : {6'h00, i_word[11:0]});
    assign o_straps_n       = 1'b0;
endmodule : dcf_far_side

//--- tb/dual_clock_fifo_prog_flags_bench.sv
// Self-checking bench for the programmable-flag FIFO
`timescale 1ns/1ps
module dual_clock_fifo_prog_flags_bench;
    localparam int D = 256;
    logic        i_clk, i_resetn, push, pop, ld_n, drv_n;
    logic [17:0] word, din, q, w, last;
    logic        we_n, re_n, st_n, oe, ff_n, ef_n, af_n, ae_n, hf_n, rxo_n;
    logic [17:0] mdl[$], expq[$];
    int          k;
    int          n_fail = 0;
    int          comparisons = 0;

    initial begin
        i_clk = 1'b0;
        forever #10 i_clk = ~i_clk;
    end
    dcf_far_side u_far (.i_clk(i_clk), .i_push(push), .i_pop(pop), .i_load_n(ld_n), .i_word(word),
        .o_write_enable_n(we_n), .o_read_enable_n(re_n), .o_data_in(din), .o_straps_n(st_n));
    dcf_fifo_top #(.DEPTH(D), .STAGE_DEPTH(4)) u_dut (.i_clk(i_clk), .i_resetn(i_resetn), .i_data_in(din),
        .i_write_enable_n(we_n), .i_read_enable_n(re_n), .i_offset_load_n(ld_n), .i_output_drive_n(drv_n),
        .i_first_in_chain_n(st_n), .i_write_chain_in_n(st_n), .i_read_chain_in_n(st_n), .o_data_out(q),
        .o_data_out_oe(oe), .o_full_flag_n(ff_n), .o_empty_flag_n(ef_n), .o_almost_full_n(af_n),
        .o_almost_empty_n(ae_n), .o_write_chain_out_n(hf_n), .o_read_chain_out_n(rxo_n));
    ////////////////////////////////////////////////////////////
    task automatic chk(input string nm, input logic [17:0] exp, input logic [17:0] got);
        comparisons++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk
    task automatic flags(input logic [4:0] exp);
        chk("flags", {13'h0000, exp}, {13'h0000, ff_n, ef_n, af_n, ae_n, hf_n});
    endtask : flags
    task automatic cyc(input logic p, input logic r, input logic l, input logic [17:0] v);
        push  <= p;
        pop   <= r;
        ld_n  <= l;
        word  <= v;
        drv_n <= 1'($urandom_range(1));
        @(negedge i_clk);
        chk("data_out_oe", !drv_n, oe);
    endtask : cyc
    task automatic wrap_up;
        if (n_fail == 0 && comparisons > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : wrap_up
    ////////////////////////////////////////////////////////////
    // Every accepted read or fetch retires the oldest note
    always @(posedge i_clk) begin
        if (i_resetn && !re_n && (!ld_n || ef_n)) begin
            #1;
            if (expq.size() == 0) chk("read count", 18'h00000, 18'h00001);
            else chk("data_out", expq.pop_front(), q);
        end
    end
    initial begin
        #(20 * 3000);
        n_fail++;
        wrap_up();
    end
    initial begin
        void'($urandom(32'hD45D));
        i_resetn = 1'b0;
        {push, pop, ld_n, drv_n} = 4'h3;
        word = 18'h00000;
        repeat (12) @(negedge i_clk);
        i_resetn <= 1'b1;
        @(negedge i_clk);
        flags(5'b10101);
        cyc(0, 1, 1, 18'h00000);
        chk("data_out", 18'h00000, q);
        repeat (2) begin
            expq.push_back(18'h0001F);
            cyc(0, 1, 0, 18'h00000);
        end
        cyc(1, 0, 0, 18'h3F002);
        cyc(0, 0, 1, 18'h00000);
        repeat (3) cyc(0, 0, 0, 18'h00000);
        cyc(1, 0, 0, 18'h00005);
        cyc(0, 0, 1, 18'h00000);
        flags(5'b10101);
        expq.push_back(18'h00002);
        cyc(0, 1, 0, 18'h00000);
        expq.push_back(18'h00005);
        cyc(0, 1, 0, 18'h00000);
        for (k = 1; k <= D; k++) begin
            w = 18'($urandom);
            mdl.push_back(w);
            cyc(1, 0, 1, w);
            chk("full_flag_n", k < D, ff_n);
            chk("almost_full_n", k < D - 5, af_n);
            chk("half_full_n", k <= D / 2, hf_n);
        end
        cyc(1, 0, 1, 18'h15A5A);
        flags(5'b01010);
        expq.push_back(mdl.pop_front());
        cyc(0, 1, 1, 18'h00000);
        cyc(0, 0, 1, 18'h00000);
        chk("full_flag_n", 1'b1, ff_n);
        // Random stalls between reads exercise the output hold
        while (mdl.size() > 0) begin
            k = ef_n && $urandom_range(1);
            if (k != 0) begin
                last = mdl[0];
                expq.push_back(mdl.pop_front());
            end
            cyc(0, k[0], 1, 18'h00000);
            flags({1'b1, mdl.size() > 0, mdl.size() < D - 5, mdl.size() > 2, mdl.size() <= D / 2});
        end
        cyc(0, 1, 1, 18'h00000);
        chk("data_out", last, q);
        cyc(1, 0, 1, 18'h2D00F);
        repeat (3) cyc(0, 0, 1, 18'h00000);
        chk("data_out", last, q);
        flags(5'b11101);
        expq.push_back(18'h2D00F);
        cyc(0, 1, 1, 18'h00000);
        chk("read backlog", 18'h00000, 18'(expq.size()));
        chk("read_chain_out_n", 18'h00001, {17'h00000, rxo_n});
        wrap_up();
    end
endmodule : dual_clock_fifo_prog_flags_bench
